// ===== rtl/ser_irq_pkg.sv
// Operation
// - both strobes low together resets device
// - status after reset reads 01xxx100b
// - status bit 5 shows clear-to-send pin
// - status bit 4 shows sync input
// - status bit 3 shows carrier-detect pin
// - baud and source-enable registers read back
// - raise request, drive vector on acknowledge
// - vector unmodified when status inclusion off
// - request needs source, master, chain enables
// - pending flag never set by software
// - 20h, 01h, 08h enable clear-to-send interrupt
// - either clear-to-send edge starts request
// - 10h resets latch, 38h clears in-service
// - vector driven only with acknowledge and read
`default_nettype none
package ser_irq_pkg;
  localparam logic [3:0] reg_command   = 4'h0;
  localparam logic [3:0] reg_int_en    = 4'h1;
  localparam logic [3:0] reg_vector    = 4'h2;
  localparam logic [3:0] reg_master    = 4'h9;
  localparam logic [3:0] reg_baud_lo   = 4'hc;
  localparam logic [3:0] reg_baud_hi   = 4'hd;
  localparam logic [3:0] reg_src_en    = 4'hf;
  localparam logic [7:0] cmd_reset_ext = 8'h10;
  localparam logic [7:0] cmd_reset_ius = 8'h38;
  localparam logic [7:0] cmd_code_mask = 8'h38;
  localparam logic [7:0] ptr_mask      = 8'h07;
  localparam logic [7:0] cmd_point_hi  = 8'h08;
  localparam int         bit_ext_ie    = 0;
  localparam int         bit_mie       = 3;
  localparam int         bit_vis       = 0;
  localparam int         bit_cts_en    = 5;
  localparam int         bit_cts       = 5;
  localparam int         bit_sync      = 4;
  localparam int         bit_dcd       = 3;
  localparam logic [7:0] status_fixed  = 8'h44;
  localparam logic [7:0] src_en_reset  = 8'hf8;
  localparam logic [7:0] zero_byte     = 8'h00;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic cts_n;
    logic sync_n;
    logic dcd_n;
  } pins_t;
endpackage
`default_nettype wire

// ===== rtl/pin_sync.sv
`default_nettype none
module pin_sync
  import ser_irq_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  srst,
  input  wire pins_t raw,
  output var  pins_t synced
);
  pins_t stage1;
  pins_t next_stage1;
  pins_t next_synced;
  localparam pins_t idle = '{rd_n: 1'b1, wr_n: 1'b1, ack_n: 1'b1,
                             cts_n: 1'b1, sync_n: 1'b1, dcd_n: 1'b1};

  // two-stage synchroniser for all pins
  always_comb
  begin
    next_stage1 = raw;
    next_synced = stage1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage1 <= idle;
      synced <= idle;
    end
    else
    begin
      stage1 <= next_stage1;
      synced <= next_synced;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/ser_irq_ctrl.sv
`default_nettype none
module ser_irq_ctrl
  import ser_irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       device_read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       irq_ack_n,
  input  wire logic       chain_enable_in,
  input  wire logic       clear_to_send_n,
  input  wire logic       sync_n,
  input  wire logic       carrier_detect_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            irq_n
);
  import ser_irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  pins_t raw;
  pins_t pin;
  assign raw = '{rd_n: device_read_strobe_n, wr_n: write_strobe_n, ack_n: irq_ack_n,
                 cts_n: clear_to_send_n, sync_n: sync_n, dcd_n: carrier_detect_n};

  pin_sync u_sync
  (
    .clock  (clock),
    .srst   (srst),
    .raw    (raw),
    .synced (pin)
  );

  logic       chain_s1;
  logic       chain_s2;
  logic       rd_q;
  logic       wr_q;
  logic [7:0] data_s1;
  logic [7:0] data_s2;

  // chain enable and write data synchronisers, strobe history
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      chain_s1 <= 1'b0;
      chain_s2 <= 1'b0;
      rd_q     <= 1'b1;
      wr_q     <= 1'b1;
      data_s1  <= zero_byte;
      data_s2  <= zero_byte;
    end
    else
    begin
      chain_s1 <= chain_enable_in;
      chain_s2 <= chain_s1;
      rd_q     <= pin.rd_n;
      wr_q     <= pin.wr_n;
      data_s1  <= data_in;
      data_s2  <= data_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic       hw_reset;
  logic       wr_edge;
  logic       rd_edge;
  assign hw_reset = !pin.rd_n && !pin.wr_n;
  assign wr_edge  = !pin.wr_n && wr_q && pin.rd_n;
  assign rd_edge  = !pin.rd_n && rd_q && pin.wr_n;

  logic [3:0] pointer;
  logic [7:0] int_en;
  logic [7:0] vector;
  logic [7:0] master;
  logic [7:0] baud_lo;
  logic [7:0] baud_hi;
  logic [7:0] src_en;
  logic       ext_latch;
  logic       cts_last;
  logic       pending;
  logic       in_service;
  logic [3:0] next_pointer;
  logic [7:0] next_int_en;
  logic [7:0] next_vector;
  logic [7:0] next_master;
  logic [7:0] next_baud_lo;
  logic [7:0] next_baud_hi;
  logic [7:0] next_src_en;
  logic       next_ext_latch;
  logic       next_cts_last;
  logic       next_pending;
  logic       next_in_service;
  logic       cts_change;
  logic       enables_ok;
  logic       ack_read;

  assign cts_change = (pin.cts_n != cts_last) && src_en[bit_cts_en];
  assign enables_ok = int_en[bit_ext_ie] && master[bit_mie] && chain_s2;
  assign ack_read   = !pin.ack_n && !pin.rd_n;

  // register writes, latch and pending flag
  always_comb
  begin
    next_pointer    = pointer;
    next_int_en     = int_en;
    next_vector     = vector;
    next_master     = master;
    next_baud_lo    = baud_lo;
    next_baud_hi    = baud_hi;
    next_src_en     = src_en;
    next_in_service = in_service;
    next_cts_last   = ext_latch ? cts_last : pin.cts_n;
    next_ext_latch  = ext_latch;
    next_pending    = pending;
    if (pin.rd_n && !rd_q)
      next_pointer = reg_command;
    if (wr_edge)
    begin
      if (pointer == reg_command)
      begin
        next_pointer = {(data_s2 & cmd_code_mask) == cmd_point_hi, data_s2[2:0] & ptr_mask[2:0]};
        if ((data_s2 & cmd_code_mask) == cmd_reset_ext)
          next_ext_latch = 1'b0;
        if ((data_s2 & cmd_code_mask) == cmd_reset_ius)
          next_in_service = 1'b0;
      end
      else
      begin
        next_pointer = reg_command;
        case (pointer)
          reg_int_en:  next_int_en  = data_s2;
          reg_vector:  next_vector  = data_s2;
          reg_master:  next_master  = data_s2;
          reg_baud_lo: next_baud_lo = data_s2;
          reg_baud_hi: next_baud_hi = data_s2;
          reg_src_en:  next_src_en  = data_s2;
          default:     next_pointer = reg_command;
        endcase
      end
    end
    if (cts_change && !ext_latch)
      next_ext_latch = 1'b1;
    next_pending = ext_latch && int_en[bit_ext_ie];
    if (ack_read && rd_edge && pending && !in_service)
      next_in_service = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst || hw_reset)
    begin
      pointer    <= reg_command;
      int_en     <= zero_byte;
      vector     <= zero_byte;
      master     <= zero_byte;
      baud_lo    <= zero_byte;
      baud_hi    <= zero_byte;
      src_en     <= src_en_reset;
      ext_latch  <= 1'b0;
      cts_last   <= 1'b1;
      pending    <= 1'b0;
      in_service <= 1'b0;
    end
    else
    begin
      pointer    <= next_pointer;
      int_en     <= next_int_en;
      vector     <= next_vector;
      master     <= next_master;
      baud_lo    <= next_baud_lo;
      baud_hi    <= next_baud_hi;
      src_en     <= next_src_en;
      ext_latch  <= next_ext_latch;
      cts_last   <= next_cts_last;
      pending    <= next_pending;
      in_service <= next_in_service;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] status;
  logic [7:0] read_mux;
  logic [7:0] next_data_out;
  logic       next_data_oe;
  logic       next_irq_n;

  // status byte and read / vector path
  always_comb
  begin
    status           = status_fixed;
    status[bit_cts]  = !pin.cts_n;
    status[bit_sync] = !pin.sync_n;
    status[bit_dcd]  = !pin.dcd_n;
    case (pointer)
      reg_baud_lo: read_mux = baud_lo;
      reg_baud_hi: read_mux = baud_hi;
      reg_src_en:  read_mux = src_en;
      default:     read_mux = status;
    endcase
    next_data_oe  = !pin.rd_n && pin.wr_n;
    next_data_out = ack_read ? vector : read_mux;
    if (ack_read && !master[bit_vis] && !chain_s2)
      next_data_oe = 1'b0;
    next_irq_n = !(pending && enables_ok && !in_service);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      data_out <= zero_byte;
      data_oe  <= 1'b0;
      irq_n    <= 1'b1;
    end
    else
    begin
      data_out <= next_data_out;
      data_oe  <= next_data_oe;
      irq_n    <= next_irq_n;
    end
  end
endmodule
`default_nettype wire

// ===== verification/ser_irq_assertions.sv
`default_nettype none
module ser_irq_assertions
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       device_read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       irq_ack_n,
  input wire logic       chain_enable_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       irq_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // bus phases seen at the pins
  sequence ack_read;
    (!irq_ack_n && !device_read_strobe_n)[*6];
  endsequence
  sequence quiet_host;
    (write_strobe_n && irq_ack_n && chain_enable_in)[*4];
  endsequence
  // output behaviour
  reset_outputs_a: assert property (disable iff (1'b0) srst |=> !data_oe && irq_n)
    else $error("outputs active after reset");
  hw_reset_a: assert property ((!device_read_strobe_n && !write_strobe_n)[*6] |-> irq_n)
    else $error("request survives strobe reset");
  vector_gate_a: assert property (data_oe |-> !$past(device_read_strobe_n, 3))
    else $error("bus driven without read strobe");
  idle_bus_a: assert property (device_read_strobe_n[*5] |-> !data_oe)
    else $error("bus driven while idle");
  read_answer_a: assert property ((!device_read_strobe_n && write_strobe_n)[*5] |-> data_oe)
    else $error("read not answered");
  vector_stable_a: assert property (ack_read |-> $stable(data_out))
    else $error("vector changed during acknowledge");
  irq_hold_a: assert property (quiet_host ##0 !irq_n |=> !irq_n)
    else $error("request dropped without cause");
  chain_gate_a: assert property ((!chain_enable_in)[*5] |-> irq_n)
    else $error("request with chain disabled");
endmodule
bind ser_irq_ctrl ser_irq_assertions chk (.clock(clock), .srst(srst), .irq_n(irq_n),
  .device_read_strobe_n(device_read_strobe_n), .write_strobe_n(write_strobe_n),
  .irq_ack_n(irq_ack_n), .chain_enable_in(chain_enable_in), .data_out(data_out),
  .data_oe(data_oe));
`default_nettype wire

// ===== verification/ack_host_model.sv
`default_nettype none
module ack_host_model
#(
  parameter int settle = 4
)
(
  input  wire logic clock,
  input  wire logic start,
  output var  logic ack_n,
  output var  logic rd_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // acknowledge first, read strobe once the chain has settled
  initial
  begin
    ack_n = 1'b1;
    rd_n = 1'b1;
  end
  always @(posedge clock)
  begin
    if (start)
    begin
      #1 ack_n = 1'b0;
      repeat (settle) @(posedge clock);
      #1 rd_n = 1'b0;
      repeat (6) @(posedge clock);
      #1 rd_n = 1'b1;
      ack_n = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/ser_irq_ctrl_tb_top.sv
`default_nettype none
module ser_irq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ser_irq_pkg::*;
  logic clock, srst, chain, start, oe, irq_n, ack_n, host_rd_n;
  logic [7:0] din, dout, v;
  pins_t p;
  int bad_count, num_checks, i;
  logic [3:0] regs [3] = '{reg_baud_lo, reg_baud_hi, reg_src_en};
  ack_host_model host (.clock(clock), .start(start), .ack_n(ack_n), .rd_n(host_rd_n));
  ser_irq_ctrl dut (.clock(clock), .srst(srst), .device_read_strobe_n(p.rd_n & host_rd_n),
    .write_strobe_n(p.wr_n), .irq_ack_n(ack_n), .chain_enable_in(chain),
    .clear_to_send_n(p.cts_n), .sync_n(p.sync_n), .carrier_detect_n(p.dcd_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .irq_n(irq_n));
  // clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait: sel 1 for bus drive, 0 for request low
  task automatic wait_for(input bit sel);
    int n;
    n = 0;
    do
    begin
      @(posedge clock) #2;
      n++;
    end
    while (!(sel ? oe === 1'b1 : irq_n === 1'b0) && n < 14);
    if (!(sel ? oe === 1'b1 : irq_n === 1'b0))
    begin
      bad_count++;
      $display("BAD t=%0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  // host bus cycles
  task automatic wr(input logic [7:0] b);
    @(posedge clock) #1 p.wr_n = 1'b0;
    din = b;
    repeat (4) @(posedge clock);
    #1 p.wr_n = 1'b1;
    repeat (4) @(posedge clock);
  endtask
  task automatic rd(output logic [7:0] r);
    @(posedge clock) #1 p.rd_n = 1'b0;
    wait_for(1'b1);
    r = dout;
    @(posedge clock) #1 p.rd_n = 1'b1;
    repeat (5) @(posedge clock);
  endtask
  // main sequence
  initial
  begin
    p = '1;
    din = 8'h00;
    srst = 1'b1;
    chain = 1'b1;
    start = 1'b0;
    repeat (16) @(posedge clock);
    #1 srst = 1'b0;
    rd(v);
    check(v, status_fixed);
    for (i = 0; i < 3; i++)
    begin
      @(posedge clock) #1 {p.cts_n, p.sync_n, p.dcd_n} = ~(3'b100 >> i);
      repeat (3) @(posedge clock);
      rd(v);
      check(v, status_fixed | (8'h20 >> i));
    end
    @(posedge clock) #1 p = '1;
    $display("status test done");
    for (i = 0; i < 3; i++)
    begin
      wr({4'h0, regs[i]});
      wr(8'h5a ^ {4'h0, regs[i]});
      wr({4'h0, regs[i]});
      rd(v);
      check(v, 8'h5a ^ {4'h0, regs[i]});
    end
    @(posedge clock) #1 p.rd_n = 1'b0;
    p.wr_n = 1'b0;
    repeat (8) @(posedge clock);
    #1 p = '1;
    wr({4'h0, reg_src_en});
    rd(v);
    check(v, src_en_reset);
    $display("readback test done");
    wr({4'h0, reg_vector});
    wr(8'h5c);
    wr({4'h0, reg_master});
    wr(8'h08);
    wr({4'h0, reg_int_en});
    wr(8'h01);
    wr({4'h0, reg_src_en});
    wr(8'h20);
    wr(cmd_reset_ext);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clock) #1 p.cts_n = ~p.cts_n;
      wait_for(1'b0);
      repeat (6) @(posedge clock);
      check({7'h00, irq_n}, 8'h00);
      if (i == 0)
      begin
        @(posedge clock) #1 start = 1'b1;
        @(posedge clock) #1 start = 1'b0;
        wait_for(1'b1);
        check(dout, 8'h5c);
        repeat (10) @(posedge clock);
        wr(cmd_reset_ext);
        wr(cmd_reset_ius);
      end
      else
      begin
        wr(cmd_reset_ext);
        check({7'h00, irq_n}, 8'h01);
      end
    end
    @(posedge clock) #1 chain = 1'b0;
    p.cts_n = ~p.cts_n;
    repeat (10) @(posedge clock);
    check({7'h00, irq_n}, 8'h01);
    $display("interrupt test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
